/* File: design/lcrb_defines.vh */
// lcrb_defines.vh - register offsets, field positions, reset values of the lane config bank
// assumes: included by bare name from the lane config design files
`ifndef LCRB_DEFINES_VH
`define LCRB_DEFINES_VH

// wishbone word byte addresses (own choice of map)
`define LCRB_ADDR_LANE_A 8'h00
`define LCRB_ADDR_LANE_B 8'h04
`define LCRB_ADDR_GLOBAL 8'h08
`define LCRB_ADDR_CTRL0 8'h0c
`define LCRB_ADDR_STAT22 8'h10
`define LCRB_ADDR_PINS 8'h14

// lane register fields
`define LCRB_BIT_CTC 11
`define LCRB_BIT_MFSEL_HI 10
`define LCRB_BIT_MFSEL_LO 9
`define LCRB_BIT_LOS 8
`define LCRB_BIT_CFGHI 7
`define LCRB_BIT_CFGLO 6
`define LCRB_BIT_PREHI 5
`define LCRB_BIT_PRELO 4
`define LCRB_BIT_LOOP 3
`define LCRB_BIT_PRBS 2
`define LCRB_BIT_COMMA 1
`define LCRB_BIT_PWDN 0

// general control register 0 fields
`define LCRB_CTRL0_LOOP 14
`define LCRB_CTRL0_PWDN 11

// status register 22 fields
`define LCRB_STAT_LOS_A 0
`define LCRB_STAT_LOS_B 1
`define LCRB_STAT_PRBS_A 4
`define LCRB_STAT_PRBS_B 5

// multifunction select codes
`define LCRB_MF_IOSTD 2'h0
`define LCRB_MF_COMMA 2'h1
`define LCRB_MF_LOS 2'h2
`define LCRB_MF_PRBS 2'h3

// reset values
`define LCRB_LANE_RESET 12'h102
`define LCRB_GLOBAL_RESET 12'h102
`define LCRB_CTRL0_RESET 16'h0000
`define LCRB_WRITE_MASK 16'h0fff

`endif

/* File: design/lcrb_pin_sync.v */
// lcrb_pin_sync.v - three-flop synchroniser for strap and status pins
// assumes: inputs are asynchronous to clk; output changes when stages two and three agree
`timescale 1ns/1ps
module lcrb_pin_sync #(
    parameter WIDTH = 1
) (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // pins
    input wire [WIDTH-1:0] pinIn,
    output reg [WIDTH-1:0] pinOut
);

reg [WIDTH-1:0] stage1_r;
reg [WIDTH-1:0] stage2_r;
reg [WIDTH-1:0] stage3_r;

//////////////////////////////////////////////////////////////////////////////
// stage one feeds only stage two; the filtered value follows agreement
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        stage1_r <= {WIDTH{1'b0}};
        stage2_r <= {WIDTH{1'b0}};
        stage3_r <= {WIDTH{1'b0}};
        pinOut <= {WIDTH{1'b0}};
    end else begin
        stage1_r <= pinIn;
        stage2_r <= stage1_r;
        stage3_r <= stage2_r;
        pinOut <= (stage2_r & stage3_r) | (pinOut & (stage2_r | stage3_r));
    end
end

endmodule // lcrb_pin_sync

/* File: design/lcrb_lane_reg.v */
// lcrb_lane_reg.v - one lane configuration register with strap-guarded bits
// assumes: pins already synchronised; write strobe is a one-cycle pulse from the bus slave
`timescale 1ns/1ps
`include "lcrb_defines.vh"
module lcrb_lane_reg #(
    parameter HAS_LOOP_STRAP = 0
) (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // write port
    input wire wrEn,
    input wire [15:0] wrData,
    input wire [1:0] wrSel,
    // strap pins guarding writes
    input wire strapCfgHigh,
    input wire strapCfgLow,
    input wire strapLoop,
    input wire strapPrbs,
    // stored and read-back values
    output reg [11:0] laneReg_r,
    output wire [15:0] readValue
);

wire [15:0] mergedWr;
wire [11:0] laneReg_nxt;
wire [11:0] pinForce;

// byte lanes merge into the stored value; upper nibble is never stored
assign mergedWr = {wrSel[1] ? wrData[15:8] : {4'h0, laneReg_r[11:8]},
                   wrSel[0] ? wrData[7:0] : laneReg_r[7:0]};

// pin-high bits are frozen: write keeps stored value
assign pinForce = {4'h0, strapCfgHigh, strapCfgLow, 2'h0,
                   (HAS_LOOP_STRAP != 0) & strapLoop, strapPrbs, 2'h0};
assign laneReg_nxt = (mergedWr[11:0] & ~pinForce) | (laneReg_r & pinForce);

//////////////////////////////////////////////////////////////////////////////
// storage; comma and los enables come out of reset set
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        laneReg_r <= `LCRB_LANE_RESET;
    end else if (wrEn) begin
        laneReg_r <= laneReg_nxt;
    end
end

// reads show the pin OR so software sees the forced one
assign readValue = {4'h0, laneReg_r | pinForce};

endmodule // lcrb_lane_reg

/* File: design/lcrb_lane_config_bank.v */
// lcrb_lane_config_bank.v - lane A/B configuration bank with wishbone slave
// assumes: classic wishbone master on clk; strap and status pins are asynchronous
`timescale 1ns/1ps
`include "lcrb_defines.vh"
module lcrb_lane_config_bank (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg wb_err_o,
    // strap and status pins
    input wire strapCfgHighPin,
    input wire strapCfgLowPin,
    input wire laneALoopbackStrap,
    input wire prbsTestStrap,
    input wire commaAlignEnablePin,
    input wire ioStandardHstl,
    input wire [1:0] commaDetected,
    input wire [7:0] signalLossStatus,
    // effective lane A controls
    output reg laneACtcEn_r,
    output reg laneALosEn_r,
    output reg [1:0] laneACfg_r,
    output reg [1:0] laneAPreemph_r,
    output reg laneALoopEn_r,
    output reg laneAPrbsEn_r,
    output reg laneACommaEn_r,
    output reg laneAPowerDown_r,
    output reg laneAMultifunctionOut_r,
    // effective lane B controls
    output reg laneBCtcEn_r,
    output reg laneBLosEn_r,
    output reg [1:0] laneBCfg_r,
    output reg [1:0] laneBPreemph_r,
    output reg laneBLoopEn_r,
    output reg laneBPrbsEn_r,
    output reg laneBCommaEn_r,
    output reg laneBPowerDown_r,
    output reg laneBMultifunctionOut_r
);

wire [4:0] pinSync;
wire strapCfgHigh;
wire strapCfgLow;
wire strapLoopA;
wire strapPrbs;
wire commaPin;
wire [7:0] statSync;
wire [1:0] commaSync;
wire ioStdSync;
wire [11:0] laneAReg;
wire [11:0] laneBReg;
wire [15:0] laneARead;
wire [15:0] laneBRead;
reg [11:0] globalReg_r;
reg [15:0] ctrl0Reg_r;
reg [31:0] rdData_nxt;
reg hit_nxt;
wire busReq;
wire wrLaneA;
wire wrLaneB;
wire [11:0] globalPinned;
wire [11:0] effA;
wire [11:0] effB;

// multifunction mux, shared by both lanes
function mfPick;
    input [1:0] sel;
    input ioStd;
    input comma;
    input signal_loss_status;
    input prbsPass;
    begin
        case (sel)
            `LCRB_MF_IOSTD: mfPick = ioStd;
            `LCRB_MF_COMMA: mfPick = comma;
            `LCRB_MF_LOS: mfPick = signal_loss_status;
            default: mfPick = prbsPass;
        endcase
    end
endfunction

// effective lane word: OR fields, AND for los and comma enables
function [11:0] laneEff;
    input [11:0] lane;
    input [11:0] glob;
    input comma;
    begin
        laneEff = lane | glob;
        laneEff[`LCRB_BIT_LOS] = lane[`LCRB_BIT_LOS] & glob[`LCRB_BIT_LOS];
        laneEff[`LCRB_BIT_COMMA] = lane[`LCRB_BIT_COMMA] & glob[`LCRB_BIT_COMMA] & comma;
    end
endfunction

//////////////////////////////////////////////////////////////////////////////
// pin synchronisers; pins are asynchronous to clk
lcrb_pin_sync #(.WIDTH(5)) uPinSync (
    .clk(clk),
    .rst_b(rst_b),
    .pinIn({strapCfgHighPin, strapCfgLowPin, laneALoopbackStrap, prbsTestStrap,
            commaAlignEnablePin}),
    .pinOut(pinSync)
);

lcrb_pin_sync #(.WIDTH(11)) uStatSync (
    .clk(clk),
    .rst_b(rst_b),
    .pinIn({ioStandardHstl, commaDetected, signalLossStatus}),
    .pinOut({ioStdSync, commaSync, statSync})
);

assign strapCfgHigh = pinSync[4];
assign strapCfgLow = pinSync[3];
assign strapLoopA = pinSync[2];
assign strapPrbs = pinSync[1];
assign commaPin = pinSync[0];

//////////////////////////////////////////////////////////////////////////////
// bus decode; one request is answered per ack cycle
assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
assign wrLaneA = busReq & wb_we_i & (wb_adr_i == `LCRB_ADDR_LANE_A);
assign wrLaneB = busReq & wb_we_i & (wb_adr_i == `LCRB_ADDR_LANE_B);

lcrb_lane_reg #(.HAS_LOOP_STRAP(1)) uLaneA (
    .clk(clk),
    .rst_b(rst_b),
    .wrEn(wrLaneA),
    .wrData(wb_dat_i[15:0]),
    .wrSel(wb_sel_i[1:0]),
    .strapCfgHigh(strapCfgHigh),
    .strapCfgLow(strapCfgLow),
    .strapLoop(strapLoopA),
    .strapPrbs(strapPrbs),
    .laneReg_r(laneAReg),
    .readValue(laneARead)
);

// lane B loopback has no strap guard
lcrb_lane_reg #(.HAS_LOOP_STRAP(0)) uLaneB (
    .clk(clk),
    .rst_b(rst_b),
    .wrEn(wrLaneB),
    .wrData(wb_dat_i[15:0]),
    .wrSel(wb_sel_i[1:0]),
    .strapCfgHigh(strapCfgHigh),
    .strapCfgLow(strapCfgLow),
    .strapLoop(1'b0),
    .strapPrbs(strapPrbs),
    .laneReg_r(laneBReg),
    .readValue(laneBRead)
);

//////////////////////////////////////////////////////////////////////////////
// global and control 0 registers: plain storage, masked to their widths
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        globalReg_r <= `LCRB_GLOBAL_RESET;
        ctrl0Reg_r <= `LCRB_CTRL0_RESET;
    end else if (busReq & wb_we_i) begin
        if (wb_adr_i == `LCRB_ADDR_GLOBAL) begin
            if (wb_sel_i[0]) globalReg_r[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) globalReg_r[11:8] <= wb_dat_i[11:8];
        end
        if (wb_adr_i == `LCRB_ADDR_CTRL0) begin
            if (wb_sel_i[0]) ctrl0Reg_r[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) ctrl0Reg_r[15:8] <= wb_dat_i[15:8];
        end
    end
end

// strap pins OR into the config and prbs bits of every lane
assign globalPinned = globalReg_r | {4'h0, strapCfgHigh, strapCfgLow, 3'h0, strapPrbs, 2'h0};
assign effA = laneEff(laneAReg, globalPinned, commaPin);
assign effB = laneEff(laneBReg, globalPinned, commaPin);

//////////////////////////////////////////////////////////////////////////////
// read mux; unmapped addresses get an error instead of ack
always @* begin
    rdData_nxt = 32'h0000_0000;
    hit_nxt = 1'b1;
    case (wb_adr_i)
        `LCRB_ADDR_LANE_A: rdData_nxt = {16'h0000, laneARead};
        `LCRB_ADDR_LANE_B: rdData_nxt = {16'h0000, laneBRead};
        `LCRB_ADDR_GLOBAL: rdData_nxt = {20'h00000, globalReg_r};
        `LCRB_ADDR_CTRL0: rdData_nxt = {16'h0000, ctrl0Reg_r};
        `LCRB_ADDR_STAT22: rdData_nxt = {24'h000000, statSync};
        `LCRB_ADDR_PINS: rdData_nxt = {24'h000000, 3'h0, pinSync};
        default: hit_nxt = 1'b0;
    endcase
end

// single-wait-state answer: ack or err one edge after the request appears
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        wb_ack_o <= 1'b0;
        wb_err_o <= 1'b0;
        wb_dat_o <= 32'h0000_0000;
    end else begin
        wb_ack_o <= busReq & hit_nxt;
        wb_err_o <= busReq & ~hit_nxt;
        wb_dat_o <= (busReq & hit_nxt & ~wb_we_i) ? rdData_nxt : 32'h0000_0000;
    end
end

//////////////////////////////////////////////////////////////////////////////
// effective controls registered so every output is a flop
always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
        laneACtcEn_r <= 1'b0;
        laneALosEn_r <= 1'b0;
        laneACfg_r <= 2'h0;
        laneAPreemph_r <= 2'h0;
        laneALoopEn_r <= 1'b0;
        laneAPrbsEn_r <= 1'b0;
        laneACommaEn_r <= 1'b0;
        laneAPowerDown_r <= 1'b0;
        laneAMultifunctionOut_r <= 1'b0;
        laneBCtcEn_r <= 1'b0;
        laneBLosEn_r <= 1'b0;
        laneBCfg_r <= 2'h0;
        laneBPreemph_r <= 2'h0;
        laneBLoopEn_r <= 1'b0;
        laneBPrbsEn_r <= 1'b0;
        laneBCommaEn_r <= 1'b0;
        laneBPowerDown_r <= 1'b0;
        laneBMultifunctionOut_r <= 1'b0;
    end else begin
        laneACtcEn_r <= effA[`LCRB_BIT_CTC];
        laneALosEn_r <= effA[`LCRB_BIT_LOS];
        laneACfg_r <= effA[`LCRB_BIT_CFGHI:`LCRB_BIT_CFGLO];
        laneAPreemph_r <= effA[`LCRB_BIT_PREHI:`LCRB_BIT_PRELO];
        laneALoopEn_r <= effA[`LCRB_BIT_LOOP] | ctrl0Reg_r[`LCRB_CTRL0_LOOP];
        laneAPrbsEn_r <= effA[`LCRB_BIT_PRBS];
        laneACommaEn_r <= effA[`LCRB_BIT_COMMA];
        laneAPowerDown_r <= effA[`LCRB_BIT_PWDN] | ctrl0Reg_r[`LCRB_CTRL0_PWDN];
        laneAMultifunctionOut_r <= mfPick(effA[`LCRB_BIT_MFSEL_HI:`LCRB_BIT_MFSEL_LO],
            ioStdSync, commaSync[0], statSync[`LCRB_STAT_LOS_A],
            statSync[`LCRB_STAT_PRBS_A]);
        laneBCtcEn_r <= effB[`LCRB_BIT_CTC];
        laneBLosEn_r <= effB[`LCRB_BIT_LOS];
        laneBCfg_r <= effB[`LCRB_BIT_CFGHI:`LCRB_BIT_CFGLO];
        laneBPreemph_r <= effB[`LCRB_BIT_PREHI:`LCRB_BIT_PRELO];
        laneBLoopEn_r <= effB[`LCRB_BIT_LOOP] | ctrl0Reg_r[`LCRB_CTRL0_LOOP];
        laneBPrbsEn_r <= effB[`LCRB_BIT_PRBS];
        laneBCommaEn_r <= effB[`LCRB_BIT_COMMA];
        laneBPowerDown_r <= effB[`LCRB_BIT_PWDN] | ctrl0Reg_r[`LCRB_CTRL0_PWDN];
        laneBMultifunctionOut_r <= mfPick(effB[`LCRB_BIT_MFSEL_HI:`LCRB_BIT_MFSEL_LO],
            ioStdSync, commaSync[1], statSync[`LCRB_STAT_LOS_B],
            statSync[`LCRB_STAT_PRBS_B]);
    end
end

endmodule // lcrb_lane_config_bank

/* File: dv/lcrb_lane_config_bank_properties.sv */
// lcrb_lane_config_bank_properties.sv - concurrent checks on the lane config bank ports
// assumes: bound to lcrb_lane_config_bank; pins held steady for several cycles when checked
`timescale 1ns/1ps
module lcrb_bank_props (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // wishbone
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    // pins
    input wire strapCfgHighPin,
    input wire strapCfgLowPin,
    input wire prbsTestStrap,
    input wire commaAlignEnablePin,
    // effective controls
    input wire laneACtcEn_r,
    input wire [1:0] laneACfg_r,
    input wire [1:0] laneBCfg_r,
    input wire [1:0] laneBPreemph_r,
    input wire laneBLoopEn_r,
    input wire laneAPrbsEn_r,
    input wire laneBPrbsEn_r,
    input wire laneACommaEn_r,
    input wire laneBCommaEn_r,
    input wire laneAPowerDown_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////////////////////
    // lane reads show a zero upper nibble; writes reach the effective controls one edge after the acked write
    AST_RSVD_ZERO: assert property (
        wb_ack_o && !wb_we_i && (wb_adr_i == 8'h00 || wb_adr_i == 8'h04)
        |-> wb_dat_o[15:12] == 4'h0) else $error("lane read shows upper bits");
    AST_CTC_SET: assert property (
        wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[1] && wb_dat_i[11]
        |=> laneACtcEn_r) else $error("clock compensation not enabled");
    AST_PREEMPH: assert property (
        wb_ack_o && wb_we_i && wb_adr_i == 8'h04 && wb_sel_i[0]
        |=> (laneBPreemph_r & $past(wb_dat_i[5:4])) == $past(wb_dat_i[5:4]))
        else $error("preemphasis bit lost");
    AST_LOOP_B: assert property (
        wb_ack_o && wb_we_i && wb_adr_i == 8'h04 && wb_sel_i[0] && wb_dat_i[3]
        |=> laneBLoopEn_r) else $error("loopback not enabled");
    AST_PWDN_A: assert property (
        wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0] && wb_dat_i[0]
        |=> laneAPowerDown_r) else $error("power down not enabled");
    // pin levels need a few edges through the synchroniser, hence the held window
    AST_CFG_HI: assert property (
        strapCfgHighPin [*7] |-> laneACfg_r[1] && laneBCfg_r[1])
        else $error("high config strap not ored");
    AST_CFG_LO: assert property (
        strapCfgLowPin [*7] |-> laneACfg_r[0] && laneBCfg_r[0])
        else $error("low config strap not ored");
    AST_PRBS_STRAP: assert property (
        prbsTestStrap [*7] |-> laneAPrbsEn_r && laneBPrbsEn_r)
        else $error("prbs strap not ored");
    AST_COMMA_PIN: assert property (
        !commaAlignEnablePin [*7] |-> !laneACommaEn_r && !laneBCommaEn_r)
        else $error("comma align active with pin low");
    AST_FROZEN_READ: assert property (
        strapCfgHighPin [*7] ##0 (wb_ack_o && !wb_we_i && (wb_adr_i == 8'h00 || wb_adr_i == 8'h04))
        |-> wb_dat_o[7]) else $error("frozen bit reads zero");
endmodule // lcrb_bank_props

/* File: dv/lcrb_lane_config_bank_test.sv */
// lcrb_lane_config_bank_test.sv - self-checking bench for the lane config bank
// assumes: design and property checker compiled first; defines header on the include path
`timescale 1ns/1ps
`include "lcrb_defines.vh"
module lcrb_lane_config_bank_test;
    typedef struct packed {logic [7:0] a; logic [15:0] d; logic [15:0] e;} lcrb_row_t;
    logic clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rdData;
    logic strapCfgHighPin, strapCfgLowPin, laneALoopbackStrap, prbsTestStrap;
    logic commaAlignEnablePin, ioStandardHstl, errSeen;
    logic [1:0] commaDetected, laneACfg_r, laneAPreemph_r, laneBCfg_r, laneBPreemph_r;
    logic [7:0] signalLossStatus;
    logic laneACtcEn_r, laneALosEn_r, laneALoopEn_r, laneAPrbsEn_r, laneACommaEn_r;
    logic laneAPowerDown_r, laneAMultifunctionOut_r, laneBCtcEn_r, laneBLosEn_r;
    logic laneBLoopEn_r, laneBPrbsEn_r, laneBCommaEn_r, laneBPowerDown_r;
    logic laneBMultifunctionOut_r;
    logic [3:0] srcA, srcB;
    int miscompares = 0;
    int nTests = 0;
    lcrb_row_t rows [6] = '{'{8'h04, 16'hffff, 16'h0fff}, '{8'h00, 16'hffff, 16'h0fff},
        '{8'h00, 16'h0a5a, 16'h0a5a}, '{8'h04, 16'h05a5, 16'h05a5},
        '{8'h00, 16'h0000, 16'h0000}, '{8'h04, 16'h0000, 16'h0000}};

    lcrb_lane_config_bank dut (
        .clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .strapCfgHighPin(strapCfgHighPin),
        .strapCfgLowPin(strapCfgLowPin), .laneALoopbackStrap(laneALoopbackStrap),
        .prbsTestStrap(prbsTestStrap), .commaAlignEnablePin(commaAlignEnablePin),
        .ioStandardHstl(ioStandardHstl), .commaDetected(commaDetected),
        .signalLossStatus(signalLossStatus), .laneACtcEn_r(laneACtcEn_r),
        .laneALosEn_r(laneALosEn_r), .laneACfg_r(laneACfg_r), .laneAPreemph_r(laneAPreemph_r),
        .laneALoopEn_r(laneALoopEn_r), .laneAPrbsEn_r(laneAPrbsEn_r),
        .laneACommaEn_r(laneACommaEn_r), .laneAPowerDown_r(laneAPowerDown_r),
        .laneAMultifunctionOut_r(laneAMultifunctionOut_r), .laneBCtcEn_r(laneBCtcEn_r),
        .laneBLosEn_r(laneBLosEn_r), .laneBCfg_r(laneBCfg_r), .laneBPreemph_r(laneBPreemph_r),
        .laneBLoopEn_r(laneBLoopEn_r), .laneBPrbsEn_r(laneBPrbsEn_r),
        .laneBCommaEn_r(laneBCommaEn_r), .laneBPowerDown_r(laneBPowerDown_r),
        .laneBMultifunctionOut_r(laneBMultifunctionOut_r)
    );

    ////////////////////////////////////////////////////////////////////////////////////////
    // one classic cycle; waits for ack or err, only the watchdog ends a wait on a dead slave
    task automatic bus(input logic [7:0] a, input logic w, input logic [15:0] d);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_sel_i <= 4'h3;
        wb_adr_i <= a;
        wb_dat_i <= {16'h0000, d};
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        rdData = wb_dat_o;
        errSeen = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    // compare a value against its expectation
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        nTests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // write then wait long enough for pins and effective outputs to settle
    task automatic wrSettle(input logic [7:0] a, input logic [15:0] d);
        bus(a, 1'b1, d);
        repeat (8) @(posedge clk);
    endtask

    task automatic stopTest();
        $display("comparisons %0d mismatches %0d", nTests, miscompares);
        if (miscompares == 0 && nTests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // free-running clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // watchdog sized well above the few hundred cycles the sequence needs
    initial begin
        #500000;
        miscompares++;
        stopTest();
    end

    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {strapCfgHighPin, strapCfgLowPin, laneALoopbackStrap, prbsTestStrap} = 4'h0;
        commaAlignEnablePin = 1'b1;
        ioStandardHstl = 1'b0;
        commaDetected = 2'h0;
        signalLossStatus = 8'h00;
        rst_b = 1'b0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk);
        bus(`LCRB_ADDR_LANE_A, 1'b0, 16'h0);
        chk("laneA reset", 32'h102, rdData);
        chk("enables", 4'hf, {laneALosEn_r, laneACommaEn_r, laneBLosEn_r, laneBCommaEn_r});
        $display("test reset done");
        // table of lane writes with read back
        foreach (rows[i]) begin
            bus(rows[i].a, 1'b1, rows[i].d);
            bus(rows[i].a, 1'b0, 16'h0);
            chk("row readback", {16'h0, rows[i].e}, rdData);
        end
        $display("test rows done");
        // every output select, two opposite source patterns
        wrSettle(`LCRB_ADDR_GLOBAL, 16'h0102);
        for (int p = 0; p < 2; p++) begin
            ioStandardHstl <= p[0];
            commaDetected <= p[0] ? 2'h1 : 2'h2;
            signalLossStatus <= p[0] ? 8'h12 : 8'h21;
            for (int s = 0; s < 4; s++) begin
                bus(`LCRB_ADDR_LANE_A, 1'b1, {5'h00, s[1:0], 9'h102});
                wrSettle(`LCRB_ADDR_LANE_B, {5'h00, s[1:0], 9'h102});
                srcA = {signalLossStatus[4], signalLossStatus[0], commaDetected[0], ioStandardHstl};
                srcB = {signalLossStatus[5], signalLossStatus[1], commaDetected[1], ioStandardHstl};
                chk("mfA", srcA[s], laneAMultifunctionOut_r);
                chk("mfB", srcB[s], laneBMultifunctionOut_r);
            end
        end
        // global select bit ored in: lane 10 with global 01 picks prbs pass
        // other sources held low so a wrong pick cannot read as one
        ioStandardHstl <= 1'b0;
        commaDetected <= 2'h0;
        bus(`LCRB_ADDR_LANE_A, 1'b1, 16'h0502);
        wrSettle(`LCRB_ADDR_GLOBAL, 16'h0302);
        chk("mfA ored", signalLossStatus[4], laneAMultifunctionOut_r);
        $display("test select done");
        // control register 0 and global ors, loss detect needs both bits
        bus(`LCRB_ADDR_LANE_A, 1'b1, 16'h0102);
        bus(`LCRB_ADDR_LANE_B, 1'b1, 16'h0000);
        bus(`LCRB_ADDR_CTRL0, 1'b1, 16'h4800);
        wrSettle(`LCRB_ADDR_GLOBAL, 16'h0000);
        chk("ctrl0 ors", 6'h3c, {laneALoopEn_r, laneBLoopEn_r, laneAPowerDown_r,
            laneBPowerDown_r, laneALosEn_r, laneBCtcEn_r});
        wrSettle(`LCRB_ADDR_GLOBAL, 16'h0932);
        chk("global ors", 7'h7f, {laneALosEn_r, laneBCtcEn_r, laneACommaEn_r,
            laneAPreemph_r, laneBPreemph_r});
        commaAlignEnablePin <= 1'b0;
        wrSettle(`LCRB_ADDR_CTRL0, 16'h0000);
        chk("comma off", 1'b0, laneACommaEn_r);
        commaAlignEnablePin <= 1'b1;
        $display("test ors done");
        // strap-guarded bits: lane A frozen at one, lane B frozen at zero, then release
        bus(`LCRB_ADDR_LANE_A, 1'b1, 16'h00cc);
        bus(`LCRB_ADDR_LANE_B, 1'b1, 16'h0000);
        {strapCfgHighPin, strapCfgLowPin, laneALoopbackStrap, prbsTestStrap} <= 4'hf;
        repeat (8) @(posedge clk);
        chk("straps ored", 6'h3f, {laneACfg_r, laneBCfg_r, laneAPrbsEn_r, laneBPrbsEn_r});
        bus(`LCRB_ADDR_LANE_A, 1'b1, 16'h0000);
        bus(`LCRB_ADDR_LANE_B, 1'b1, 16'h0008);
        bus(`LCRB_ADDR_LANE_A, 1'b0, 16'h0);
        chk("laneA frozen", 32'hcc, rdData);
        bus(`LCRB_ADDR_LANE_B, 1'b0, 16'h0);
        chk("laneB forced", 32'hcc, rdData);
        {strapCfgHighPin, strapCfgLowPin, laneALoopbackStrap, prbsTestStrap} <= 4'h0;
        repeat (8) @(posedge clk);
        bus(`LCRB_ADDR_LANE_A, 1'b0, 16'h0);
        chk("laneA kept", 32'hcc, rdData);
        bus(`LCRB_ADDR_LANE_B, 1'b0, 16'h0);
        chk("laneB kept", 32'h08, rdData);
        bus(8'h40, 1'b0, 16'h0);
        chk("unmapped err", 1'b1, errSeen);
        $display("test straps done");
        // reset in mid-run restores defaults
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk);
        bus(`LCRB_ADDR_LANE_B, 1'b0, 16'h0);
        chk("laneB reset", 32'h102, rdData);
        $display("test second reset done");
        stopTest();
    end
endmodule // lcrb_lane_config_bank_test

bind lcrb_lane_config_bank lcrb_bank_props props (
    .clk(clk), .rst_b(rst_b), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .strapCfgHighPin(strapCfgHighPin), .strapCfgLowPin(strapCfgLowPin),
    .prbsTestStrap(prbsTestStrap), .commaAlignEnablePin(commaAlignEnablePin),
    .laneACtcEn_r(laneACtcEn_r), .laneACfg_r(laneACfg_r), .laneBCfg_r(laneBCfg_r),
    .laneBPreemph_r(laneBPreemph_r), .laneBLoopEn_r(laneBLoopEn_r),
    .laneAPrbsEn_r(laneAPrbsEn_r), .laneBPrbsEn_r(laneBPrbsEn_r),
    .laneACommaEn_r(laneACommaEn_r), .laneBCommaEn_r(laneBCommaEn_r),
    .laneAPowerDown_r(laneAPowerDown_r)
);
